// ===== cmp_pwm_pkg.sv
/*
  constants for the compare / pwm channel: register map, field
  positions, reset values, mode codes. assumes a 32-bit axi4-lite bus.
*/
package cmp_pwm_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] CTRL1_OFS  = 8'h00;
  localparam logic [7:0] CTRL2_OFS  = 8'h04;
  localparam logic [7:0] PRIM_OFS   = 8'h08;
  localparam logic [7:0] SEC_OFS    = 8'h0C;
  localparam logic [7:0] PERIOD_OFS = 8'h10;
  localparam logic [7:0] COUNT_OFS  = 8'h14;
  localparam logic [7:0] ISTAT_OFS  = 8'h18;
  localparam logic [7:0] ICLR_OFS   = 8'h1C;
  localparam logic [7:0] IEN_OFS    = 8'h20;
  // ==========================================
  // field positions
  localparam int IDLE_HALT_B  = 13;
  localparam int TSEL_LSB     = 10;
  localparam int FEN_LSB      = 7;
  localparam int FFLAG_LSB    = 4;
  localparam int TRIG_POL_B   = 3;
  localparam int DCB_LSB      = 9;
  localparam int TRIG_MODE_B  = 7;
  localparam int TRIG_RUN_B   = 6;
  localparam logic [15:0] CTRL1_WMASK = 16'h3F8F;
  localparam logic [15:0] CTRL2_WMASK = 16'hF7BF;
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [2:0]  TSEL_SYSCLK = 3'b111;
  localparam logic [2:0]  TSEL_T1     = 3'b100;
  localparam int          IRQ_W       = 4;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  // ==========================================
  // compare modes
  typedef enum logic [2:0] {
    M_OFF    = 3'b000,
    M_SET_HI = 3'b001,
    M_SET_LO = 3'b010,
    M_TOGGLE = 3'b011,
    M_DBL_1  = 3'b100,
    M_DBL_C  = 3'b101,
    M_PWM_E  = 3'b110,
    M_PWM_C  = 3'b111
  } mode_t;
endpackage

// ===== compare_pwm_core.sv
/*
  one output compare / pwm channel behind an axi4-lite slave.
  assumes timer ticks are one-cycle pulses synchronous to aclk.
*/
// Summary of operation
// - period lasts period value plus one counts
// - duty values latched at period end in pwm modes, every cycle otherwise
// - all zero values give constant low
// - secondary above period gives constant high
// - two-bit field delays falling edge outside set-high mode
// - delay field double-buffered in pwm modes
// - delay counted in system clock periods
// - idle-halt bit stops channel during idle
// - select field picks timer or system clock
// - three enables gate the fault inputs
// - fault flags hardware set/clear, center pwm
// - comparator source depends on channel number
// - policy bit lets secondary match clear running
// - control one bits 15:14 read zero
// - mode field selects eight compare behaviours
// - codes give 0, 1, 2, 3 cycle delay outside set-high mode, 0 in it
// - timer held clear until triggered
`timescale 1ns/1ps
module compare_pwm_core #(
  parameter int CHANNEL = 1
) (
  input  wire logic        aclk,            // system clock, 125 MHz
  input  wire logic        aresetn,         // sync reset, active low
  input  wire logic [7:0]  awaddr,          // write address
  input  wire logic        awvalid,         // write address valid
  output logic             awready,         // write address ready
  input  wire logic [31:0] wdata,           // write data
  input  wire logic [3:0]  wstrb,           // write byte strobes
  input  wire logic        wvalid,          // write data valid
  output logic             wready,          // write data ready
  output logic [1:0]       bresp,           // write response
  output logic             bvalid,          // write response valid
  input  wire logic        bready,          // write response ready
  input  wire logic [7:0]  araddr,          // read address
  input  wire logic        arvalid,         // read address valid
  output logic             arready,         // read address ready
  output logic [31:0]      rdata,           // read data
  output logic [1:0]       rresp,           // read response
  output logic             rvalid,          // read data valid
  input  wire logic        rready,          // read data ready
  input  wire logic [4:0]  timer_tick,      // timer1..timer5 count pulses
  input  wire logic        cpu_idle,        // processor in idle
  input  wire logic        trigger_event,   // hardware trigger pulse
  input  wire logic        first_fault_input,  // first external fault
  input  wire logic        second_fault_input, // second external fault
  input  wire logic [2:0]  comparator_fault,   // comparators 1..3
  output logic             compare_output_pin, // compare output
  output logic             irq              // level interrupt
);
  // ==========================================
  // registers
  logic [15:0] ctrl1_q, ctrl2_q, prim_q, sec_q, per_q, cnt_q;
  logic [15:0] prim_sh_q, sec_sh_q;
  logic [1:0]  dcb_sh_q, dly_q;
  logic [2:0]  flt_q;
  logic        run_flag_q, cmp_q, done_q, out_q;
  logic [cmp_pwm_pkg::IRQ_W-1:0] ist_q, ien_q;
  logic        aw_v_q, w_v_q, bvalid_q, rvalid_q;
  logic [7:0]  aw_a_q;
  logic [31:0] w_d_q, rdata_q;
  logic [3:0]  w_s_q;
  logic [1:0]  bresp_q, rresp_q;

  function automatic logic [15:0] merge(input logic [15:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  // ==========================================
  // bus decode
  wire do_wr = aw_v_q & w_v_q & ~bvalid_q;
  wire wr_c1 = do_wr & (aw_a_q == cmp_pwm_pkg::CTRL1_OFS);
  wire wr_c2 = do_wr & (aw_a_q == cmp_pwm_pkg::CTRL2_OFS);
  wire wr_pr = do_wr & (aw_a_q == cmp_pwm_pkg::PRIM_OFS);
  wire wr_se = do_wr & (aw_a_q == cmp_pwm_pkg::SEC_OFS);
  wire wr_pe = do_wr & (aw_a_q == cmp_pwm_pkg::PERIOD_OFS);
  wire wr_ic = do_wr & (aw_a_q == cmp_pwm_pkg::ICLR_OFS);
  wire wr_ie = do_wr & (aw_a_q == cmp_pwm_pkg::IEN_OFS);
  wire wr_ok = wr_c1 | wr_c2 | wr_pr | wr_se | wr_pe | wr_ic | wr_ie
             | (aw_a_q == cmp_pwm_pkg::COUNT_OFS)
             | (aw_a_q == cmp_pwm_pkg::ISTAT_OFS);
  wire ar_hs = arvalid & ~rvalid_q;

  // ==========================================
  // control fields
  cmp_pwm_pkg::mode_t mode;
  assign mode = cmp_pwm_pkg::mode_t'(ctrl1_q[2:0]);
  wire [2:0] tsel   = ctrl1_q[cmp_pwm_pkg::TSEL_LSB +: 3];
  wire [2:0] f_en   = ctrl1_q[cmp_pwm_pkg::FEN_LSB +: 3];
  wire       halt   = ctrl1_q[cmp_pwm_pkg::IDLE_HALT_B] & cpu_idle;
  wire       pol    = ctrl1_q[cmp_pwm_pkg::TRIG_POL_B];
  wire       trig_m = ctrl2_q[cmp_pwm_pkg::TRIG_MODE_B];
  wire [1:0] dcb    = ctrl2_q[cmp_pwm_pkg::DCB_LSB +: 2];
  wire       is_pwm = (mode == cmp_pwm_pkg::M_PWM_E) | (mode == cmp_pwm_pkg::M_PWM_C);

  // ==========================================
  // time base
  // source select
  wire [2:0] t_idx = {1'b0, tsel[1:0]} + 3'd1;
  wire tick = ~tsel[2] ? timer_tick[t_idx]
            : (tsel == cmp_pwm_pkg::TSEL_T1) ? timer_tick[0]
            : (tsel == cmp_pwm_pkg::TSEL_SYSCLK);
  wire held = trig_m & ~run_flag_q;
  wire run  = tick & ~halt & ~held & (mode != cmp_pwm_pkg::M_OFF);
  wire p_end   = run & (cnt_q == per_q);
  wire match_p = run & (cnt_q == prim_sh_q);
  wire match_s = run & (cnt_q == sec_sh_q);

  always_ff @(posedge aclk) begin
    if (!aresetn | held)
      cnt_q <= cmp_pwm_pkg::REG_RESET;
    else if (run)
      cnt_q <= p_end ? cmp_pwm_pkg::REG_RESET : cnt_q + 16'h0001;
  end

  wire load_sh = p_end | ~is_pwm;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prim_sh_q <= cmp_pwm_pkg::REG_RESET;
      sec_sh_q  <= cmp_pwm_pkg::REG_RESET;
      dcb_sh_q  <= 2'b00;
    end else if (load_sh) begin
      prim_sh_q <= prim_q;
      sec_sh_q  <= sec_q;
      dcb_sh_q  <= dcb;
    end
  end

  // ==========================================
  // faults
  // comparator per channel
  localparam int CMP_IDX = (CHANNEL <= 2) ? 0 : (CHANNEL <= 4) ? 1 : 2;
  wire [2:0] f_in = f_en & {comparator_fault[CMP_IDX],
                            second_fault_input, first_fault_input};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flt
      logic flag_q;
      // set in center pwm, hw clear
      always_ff @(posedge aclk) begin
        if (!aresetn)
          flag_q <= 1'b0;
        else if (f_in[gi] & (mode == cmp_pwm_pkg::M_PWM_C))
          flag_q <= 1'b1;
        else if (p_end)
          flag_q <= 1'b0;
      end
      // one driver per bit keeps each flop in its own process
      assign flt_q[gi] = flag_q;
    end
  endgenerate
  wire fault = |flt_q;

  // ==========================================
  // trigger running flag
  wire sw_run_wr = wr_c2 & w_s_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn)
      run_flag_q <= 1'b0;
    else if (trigger_event)
      run_flag_q <= 1'b1;
    else if (sw_run_wr)
      run_flag_q <= w_d_q[cmp_pwm_pkg::TRIG_RUN_B];
    else if (pol & (cnt_q == sec_sh_q))
      run_flag_q <= 1'b0;
  end

  // ==========================================
  // compare modes
  // per-mode output behaviour
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_q  <= 1'b0;
      done_q <= 1'b0;
    end else if (wr_c1) begin
      cmp_q  <= (w_d_q[2:0] == cmp_pwm_pkg::M_SET_LO);
      done_q <= 1'b0;
    end else begin
      case (mode)
        cmp_pwm_pkg::M_SET_HI: if (match_p & ~done_q) begin
          cmp_q  <= 1'b1;
          done_q <= 1'b1;
        end
        cmp_pwm_pkg::M_SET_LO: if (match_p & ~done_q) begin
          cmp_q  <= 1'b0;
          done_q <= 1'b1;
        end
        cmp_pwm_pkg::M_TOGGLE: if (match_p)
          cmp_q <= ~cmp_q;
        cmp_pwm_pkg::M_DBL_1: if (~done_q) begin
          // a secondary match before the rise must not end the shot
          if (match_s & cmp_q) begin
            cmp_q  <= 1'b0;
            done_q <= 1'b1;
          end else if (match_p)
            cmp_q <= 1'b1;
        end
        cmp_pwm_pkg::M_DBL_C: begin
          if (match_s)
            cmp_q <= 1'b0;
          else if (match_p)
            cmp_q <= 1'b1;
        end
        default: cmp_q <= 1'b0;
      endcase
    end
  end

  wire pwm_lvl = (sec_sh_q > per_q)
               | ((cnt_q >= prim_sh_q) & (cnt_q < sec_sh_q));
  wire want    = is_pwm ? (pwm_lvl & ~fault) : cmp_q;

  // ==========================================
  // falling edge delay in whole clock cycles
  // code is a count of sysclk cycles
  wire [1:0] dcb_act = (mode == cmp_pwm_pkg::M_SET_HI) ? 2'b00
                     : is_pwm ? dcb_sh_q : dcb;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 1'b0;
      dly_q <= 2'b00;
    end else if (want | ~out_q) begin
      out_q <= want;
      dly_q <= 2'b00;
    end else if (dly_q < dcb_act)
      dly_q <= dly_q + 2'b01;
    else
      out_q <= 1'b0;
  end
  assign compare_output_pin = out_q;

  // ==========================================
  // register writes
  wire [cmp_pwm_pkg::IRQ_W-1:0] ev = {|(f_in & ~flt_q) & (mode == cmp_pwm_pkg::M_PWM_C),
                         p_end, match_s, match_p};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q <= cmp_pwm_pkg::REG_RESET;
      ctrl2_q <= cmp_pwm_pkg::REG_RESET;
      prim_q  <= cmp_pwm_pkg::REG_RESET;
      sec_q   <= cmp_pwm_pkg::REG_RESET;
      per_q   <= cmp_pwm_pkg::REG_RESET;
      ien_q   <= '0;
    end else begin
      if (wr_c1)
        ctrl1_q <= merge(ctrl1_q, w_d_q, w_s_q) & cmp_pwm_pkg::CTRL1_WMASK;
      if (wr_c2)
        ctrl2_q <= merge(ctrl2_q, w_d_q, w_s_q) & cmp_pwm_pkg::CTRL2_WMASK;
      if (wr_pr)
        prim_q <= merge(prim_q, w_d_q, w_s_q);
      if (wr_se)
        sec_q <= merge(sec_q, w_d_q, w_s_q);
      if (wr_pe)
        per_q <= merge(per_q, w_d_q, w_s_q);
      if (wr_ie & w_s_q[0])
        ien_q <= w_d_q[cmp_pwm_pkg::IRQ_W-1:0];
    end
  end

  // set wins over a same-cycle clear
  wire [cmp_pwm_pkg::IRQ_W-1:0] iclr =
      (wr_ic & w_s_q[0]) ? w_d_q[cmp_pwm_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ist_q <= '0;
    else
      ist_q <= (ist_q & ~iclr) | ev;
  end
  assign irq = |(ist_q & ien_q);

  // ==========================================
  // read mux
  wire [15:0] c1_rd = {ctrl1_q[15:7], flt_q, ctrl1_q[3:0]};
  wire [15:0] c2_rd = {ctrl2_q[15:7], run_flag_q, ctrl2_q[5:0]};
  wire [15:0] rd16 =
      (araddr == cmp_pwm_pkg::CTRL1_OFS)  ? c1_rd  :
      (araddr == cmp_pwm_pkg::CTRL2_OFS)  ? c2_rd  :
      (araddr == cmp_pwm_pkg::PRIM_OFS)   ? prim_q :
      (araddr == cmp_pwm_pkg::SEC_OFS)    ? sec_q  :
      (araddr == cmp_pwm_pkg::PERIOD_OFS) ? per_q  :
      (araddr == cmp_pwm_pkg::COUNT_OFS)  ? cnt_q  :
      (araddr == cmp_pwm_pkg::ISTAT_OFS)  ? {12'h000, ist_q} :
      (araddr == cmp_pwm_pkg::IEN_OFS)    ? {12'h000, ien_q} : 16'h0000;
  wire rd_ok = (araddr <= cmp_pwm_pkg::IEN_OFS) & (araddr[1:0] == 2'b00)
             & (araddr != cmp_pwm_pkg::ICLR_OFS);

  // ==========================================
  // axi4-lite handshakes
  assign awready = ~aw_v_q;
  assign wready  = ~w_v_q;
  assign arready = ~rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_q   <= 1'b0;
      w_v_q    <= 1'b0;
      aw_a_q   <= 8'h00;
      w_d_q    <= 32'h0000_0000;
      w_s_q    <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= cmp_pwm_pkg::RESP_OKAY;
    end else begin
      if (awvalid & ~aw_v_q) begin
        aw_v_q <= 1'b1;
        aw_a_q <= awaddr;
      end
      if (wvalid & ~w_v_q) begin
        w_v_q <= 1'b1;
        w_d_q <= wdata;
        w_s_q <= wstrb;
      end
      if (do_wr) begin
        aw_v_q   <= 1'b0;
        w_v_q    <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? cmp_pwm_pkg::RESP_OKAY : cmp_pwm_pkg::RESP_SLVERR;
      end else if (bready)
        bvalid_q <= 1'b0;
    end
  end

  logic rd_c1_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= cmp_pwm_pkg::RESP_OKAY;
      rd_c1_q  <= 1'b0;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {16'h0000, rd16};
      rresp_q  <= rd_ok ? cmp_pwm_pkg::RESP_OKAY : cmp_pwm_pkg::RESP_SLVERR;
      rd_c1_q  <= (araddr == cmp_pwm_pkg::CTRL1_OFS);
    end else if (rready)
      rvalid_q <= 1'b0;
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wrap; p_end |=> cnt_q == 16'h0000; endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at period");
  property p_latch; p_end & ~wr_se |=> sec_sh_q == $past(sec_q); endproperty
  a_latch: assert property (p_latch) else $error("duty not latched");
  property p_zero;
    is_pwm & ~|{prim_sh_q, sec_sh_q, per_q} |-> ~want;
  endproperty
  a_zero: assert property (p_zero) else $error("zero duty not low");
  property p_full; is_pwm & ~fault & (sec_sh_q > per_q) |=> out_q; endproperty
  a_full: assert property (p_full) else $error("full duty not high");
  property p_dly;
    out_q & ~want & (dly_q == 2'b00) & (dcb_act == 2'b10) |=> out_q;
  endproperty
  a_dly: assert property (p_dly) else $error("fall not delayed");
  property p_halt; halt & ~held |=> $stable(cnt_q); endproperty
  a_halt: assert property (p_halt) else $error("count moved in idle");
  property p_flt;
    f_in[0] & (mode == cmp_pwm_pkg::M_PWM_C) |=> flt_q[0];
  endproperty
  a_flt: assert property (p_flt) else $error("fault flag missed");
  property p_tclr;
    pol & (cnt_q == sec_sh_q) & ~trigger_event & ~sw_run_wr |=> ~run_flag_q;
  endproperty
  a_tclr: assert property (p_tclr) else $error("running not cleared");
  property p_rsv; rvalid_q & rd_c1_q |-> rdata_q[15:14] == 2'b00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_hold; held |=> cnt_q == 16'h0000; endproperty
  a_hold: assert property (p_hold) else $error("count not held");

  c_pend: cover property (p_end ##[1:64] p_end);
  c_fault: cover property (fault & is_pwm);
  c_stretch: cover property (out_q & ~want ##1 out_q & ~want);
endmodule // compare_pwm_core

// ===== pwm_load.sv
/*
  far-side model: a power load hanging on the compare output pin.
  it measures the pin's high time and its rise-to-rise distance in aclk cycles.
  assumes that the pin changes only on aclk.
*/
`timescale 1ns/1ps
module pwm_load (
  input  wire logic aclk,     // system clock
  input  wire logic pin,      // compare output pin
  output int        hi_len,   // last completed high run
  output int        per_len   // last rise-to-rise distance
);
  bit prev_q;
  int hi_q;
  int since_q;

  // ==========================================
  // pulse measurement
  always @(posedge aclk) begin
    prev_q <= pin;
    hi_q   <= pin ? hi_q + 1 : 0;
    if (!pin && prev_q)
      hi_len <= hi_q;
    if (pin && !prev_q) begin
      per_len <= since_q;
      since_q <= 1;
    end else
      since_q <= since_q + 1;
  end
endmodule // pwm_load

// ===== compare_pwm_core_tb.sv
/*
  self-checking bench for compare_pwm_core: axi4-lite master tasks,
  one task per scenario, and a pwm_load model on the pin.
  assumes the register map and timing given in the cmp_pwm_pkg package.
*/
`timescale 1ns/1ps
module compare_pwm_core_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [4:0]  timer_tick = 5'h00;
  logic        cpu_idle = 1'b0, trigger_event = 1'b0;
  logic        first_fault_input = 1'b0, second_fault_input = 1'b0;
  logic [2:0]  comparator_fault = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, compare_output_pin, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          hi_len, per_len;
  int          n_errors = 0;
  int          check_count = 0;
  logic [1:0]  wr_resp = 2'b00;

  always #4 aclk = ~aclk;

  compare_pwm_core #(.CHANNEL(1)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .timer_tick(timer_tick), .cpu_idle(cpu_idle),
    .trigger_event(trigger_event), .first_fault_input(first_fault_input),
    .second_fault_input(second_fault_input), .comparator_fault(comparator_fault),
    .compare_output_pin(compare_output_pin), .irq(irq));

  pwm_load load (.aclk(aclk), .pin(compare_output_pin), .hi_len(hi_len), .per_len(per_len));

  // ==========================================
  // reporting
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
    stop_test();
  endtask

  // ==========================================
  // axi4-lite master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    wr_resp = bresp;
    bready <= 1'b0;
    if (i == 50)
      hang();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (i == 50)
      hang();
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, exp);
  endtask

  task automatic pulse(input logic [4:0] m);
    @(posedge aclk);
    timer_tick <= m;
    @(posedge aclk);
    timer_tick <= 5'h00;
  endtask

  task automatic trig();
    @(posedge aclk);
    trigger_event <= 1'b1;
    @(posedge aclk);
    trigger_event <= 1'b0;
  endtask

  // pin must hold one level for sixteen cycles
  task automatic steady(input logic lvl);
    logic ok;
    ok = 1'b1;
    repeat (16) begin
      @(negedge aclk);
      if (compare_output_pin !== lvl)
        ok = 1'b0;
    end
    chk(ok, 1'b1);
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rchk(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_0000);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_FFFF);
    chk({30'h0, wr_resp}, {30'h0, cmp_pwm_pkg::RESP_OKAY});
    rchk(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_3F8F);
    // each of the eight mode codes reads back as written
    for (int m = 0; m < 8; m++) begin
      wr(cmp_pwm_pkg::CTRL1_OFS, 32'(m));
      rchk(cmp_pwm_pkg::CTRL1_OFS, 32'(m));
    end
    rd(8'h24, d, r);
    chk({30'h0, r}, {30'h0, cmp_pwm_pkg::RESP_SLVERR});
    rd(cmp_pwm_pkg::ICLR_OFS, d, r);
    chk(d, 32'h0000_0000);
    wr(8'h24, 32'h0000_0000);
    chk({30'h0, wr_resp}, {30'h0, cmp_pwm_pkg::RESP_SLVERR});
    $display("test regs done");
  endtask

  task automatic t_pwm();
    wr(cmp_pwm_pkg::PERIOD_OFS, 32'h0000_0007);
    wr(cmp_pwm_pkg::PRIM_OFS, 32'h0000_0000);
    wr(cmp_pwm_pkg::SEC_OFS, 32'h0000_0003);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1C06);
    for (int c = 0; c < 4; c++) begin
      wr(cmp_pwm_pkg::CTRL2_OFS, 32'(c << 9));
      repeat (24) @(posedge aclk);
      chk(32'(per_len), 32'h0000_0008);
      chk(32'(hi_len), 32'(3 + c));
    end
    wr(cmp_pwm_pkg::CTRL2_OFS, 32'h0000_0000);
    wr(cmp_pwm_pkg::SEC_OFS, 32'h0000_0005);
    repeat (24) @(posedge aclk);
    chk(32'(hi_len), 32'h0000_0005);
    wr(cmp_pwm_pkg::SEC_OFS, 32'h0000_0009);
    repeat (16) @(posedge aclk);
    steady(1'b1);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_0000);
    wr(cmp_pwm_pkg::SEC_OFS, 32'h0000_0000);
    wr(cmp_pwm_pkg::PERIOD_OFS, 32'h0000_0000);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1C06);
    steady(1'b0);
    $display("test pwm done");
  endtask

  task automatic t_tsel();
    logic [31:0] c0, c1;
    logic [1:0]  r;
    logic [4:0]  good;
    wr(cmp_pwm_pkg::PERIOD_OFS, 32'h0000_FFFF);
    for (int t = 0; t < 6; t++) begin
      good = (t == 4) ? 5'h01 : (t < 4) ? 5'(2 << t) : 5'h00;
      wr(cmp_pwm_pkg::CTRL1_OFS, 32'((t << 10) | 3));
      rd(cmp_pwm_pkg::COUNT_OFS, c0, r);
      pulse(~good);
      repeat (3) pulse(good);
      rd(cmp_pwm_pkg::COUNT_OFS, c1, r);
      chk({16'h0, c1[15:0] - c0[15:0]}, (t < 5) ? 32'h0000_0003 : 32'h0000_0000);
    end
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_3C03);
    cpu_idle <= 1'b1;
    rd(cmp_pwm_pkg::COUNT_OFS, c0, r);
    rd(cmp_pwm_pkg::COUNT_OFS, c1, r);
    chk(c1, c0);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1C03);
    rd(cmp_pwm_pkg::COUNT_OFS, c0, r);
    rd(cmp_pwm_pkg::COUNT_OFS, c1, r);
    chk(32'(c1 != c0), 32'h0000_0001);
    cpu_idle <= 1'b0;
    $display("test timebase done");
  endtask

  task automatic t_trig();
    wr(cmp_pwm_pkg::SEC_OFS, 32'h0000_0014);
    wr(cmp_pwm_pkg::CTRL2_OFS, 32'h0000_0080);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1C03);
    rchk(cmp_pwm_pkg::COUNT_OFS, 32'h0000_0000);
    trig();
    repeat (40) @(posedge aclk);
    rchk(cmp_pwm_pkg::CTRL2_OFS, 32'h0000_00C0);
    wr(cmp_pwm_pkg::CTRL2_OFS, 32'h0000_0080);
    rchk(cmp_pwm_pkg::COUNT_OFS, 32'h0000_0000);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1C0B);
    trig();
    repeat (40) @(posedge aclk);
    rchk(cmp_pwm_pkg::CTRL2_OFS, 32'h0000_0080);
    rchk(cmp_pwm_pkg::COUNT_OFS, 32'h0000_0000);
    wr(cmp_pwm_pkg::CTRL2_OFS, 32'h0000_0000);
    $display("test trigger done");
  endtask

  task automatic t_fault();
    wr(cmp_pwm_pkg::PERIOD_OFS, 32'h0000_0007);
    wr(cmp_pwm_pkg::SEC_OFS, 32'h0000_0003);
    wr(cmp_pwm_pkg::IEN_OFS, 32'h0000_0008);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1E87);
    second_fault_input <= 1'b1;
    comparator_fault   <= 3'h6;
    repeat (16) @(posedge aclk);
    rchk(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1E87);
    @(negedge aclk);
    chk(irq, 1'b0);
    @(posedge aclk);
    first_fault_input <= 1'b1;
    comparator_fault  <= 3'h7;
    repeat (16) @(posedge aclk);
    rchk(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1ED7);
    @(negedge aclk);
    chk(compare_output_pin, 1'b0);
    chk(irq, 1'b1);
    wr(cmp_pwm_pkg::IEN_OFS, 32'h0000_0000);
    @(negedge aclk);
    chk(irq, 1'b0);
    @(posedge aclk);
    first_fault_input  <= 1'b0;
    second_fault_input <= 1'b0;
    comparator_fault   <= 3'h0;
    repeat (16) @(posedge aclk);
    rchk(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1E87);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_0000);
    wr(cmp_pwm_pkg::PERIOD_OFS, 32'h0000_FFFF);
    wr(cmp_pwm_pkg::PRIM_OFS, 32'h0000_FFFF);
    wr(cmp_pwm_pkg::SEC_OFS, 32'h0000_FFFF);
    wr(cmp_pwm_pkg::ICLR_OFS, 32'h0000_000F);
    wr(cmp_pwm_pkg::IEN_OFS, 32'h0000_000F);
    rchk(cmp_pwm_pkg::ISTAT_OFS, 32'h0000_0000);
    @(negedge aclk);
    chk(irq, 1'b0);
    $display("test fault done");
  endtask

  // non-pwm modes on the system clock, period 8, rise at 2, fall at 5
  task automatic t_modes();
    wr(cmp_pwm_pkg::PERIOD_OFS, 32'h0000_0007);
    wr(cmp_pwm_pkg::PRIM_OFS, 32'h0000_0002);
    wr(cmp_pwm_pkg::SEC_OFS, 32'h0000_0005);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1C05);
    repeat (24) @(posedge aclk);
    chk(32'(hi_len), 32'h0000_0003);
    chk(32'(per_len), 32'h0000_0008);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1C01);
    repeat (16) @(posedge aclk);
    steady(1'b1);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1C02);
    repeat (16) @(posedge aclk);
    steady(1'b0);
    wr(cmp_pwm_pkg::CTRL1_OFS, 32'h0000_1C04);
    repeat (16) @(posedge aclk);
    chk(32'(hi_len), 32'h0000_0003);
    steady(1'b0);
    $display("test modes done");
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pwm();
    t_tsel();
    t_trig();
    t_fault();
    t_modes();
    stop_test();
  end
endmodule // compare_pwm_core_tb
